// ---- core/sdor_params.svh ----
/*
 * Register indices, field positions, reset values and field codes of the
 * vendor option register bank.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef SDOR_PARAMS_SVH
`define SDOR_PARAMS_SVH

// ==========================================================
// logical device numbers
`define SDOR_LDN_FLOPPY       8'h00
`define SDOR_LDN_PARALLEL     8'h03
`define SDOR_LDN_SERIAL1      8'h04

// ==========================================================
// register indices
`define SDOR_IDX_MODE         8'hF0
`define SDOR_IDX_OPTION       8'hF1
`define SDOR_IDX_TYPES        8'hF2
`define SDOR_IDX_ZERO         8'hF3
`define SDOR_IDX_DRV0         8'hF4
`define SDOR_IDX_DRV1         8'hF5

// ==========================================================
// reset values
`define SDOR_RST_FMODE        8'h0E
`define SDOR_RST_FOPT         8'h00
`define SDOR_RST_FTYPES       8'hFF
`define SDOR_RST_DRV          8'h00
`define SDOR_RST_PMODE        8'h3C
`define SDOR_RST_PMODE2       8'h00
`define SDOR_RST_SMODE        8'h00

// ==========================================================
// writable bit masks, reserved bits read as zero
`define SDOR_MASK_FMODE       8'hDF
`define SDOR_MASK_FOPT        8'hCC
`define SDOR_MASK_FTYPES      8'hFF
`define SDOR_MASK_DRV         8'h5B
`define SDOR_MASK_PMODE       8'hFF
`define SDOR_MASK_PMODE2      8'h03
`define SDOR_MASK_SMODE       8'h83

// ==========================================================
// field positions
`define SDOR_FM_ENH           0
`define SDOR_FM_NOBURST       1
`define SDOR_FM_IF_LO         2
`define SDOR_FM_IF_HI         3
`define SDOR_FM_SWAP          4
`define SDOR_FM_PUSHPULL      6
`define SDOR_FM_TRISTATE      7
`define SDOR_FO_DENS_LO       2
`define SDOR_FO_DENS_HI       3
`define SDOR_FO_BOOT_LO       6
`define SDOR_FO_BOOT_HI       7
`define SDOR_DR_TYPE_LO       0
`define SDOR_DR_TYPE_HI       1
`define SDOR_DR_RATE_LO       3
`define SDOR_DR_RATE_HI       4
`define SDOR_DR_PRECOMP       6
`define SDOR_FT_A_LO          0
`define SDOR_FT_A_HI          1
`define SDOR_FT_B_LO          2
`define SDOR_FT_B_HI          3
`define SDOR_PM_MODE_LO       0
`define SDOR_PM_MODE_HI       2
`define SDOR_PM_THR_LO        3
`define SDOR_PM_THR_HI        6
`define SDOR_PM_PULSE         7
`define SDOR_PM2_MUX_LO       0
`define SDOR_PM2_MUX_HI       1
`define SDOR_SM_MIDI          0
`define SDOR_SM_HISPEED       1
`define SDOR_SM_SHARE         7

// ==========================================================
// field codes
`define SDOR_DENS_FORCE1      2'h2
`define SDOR_DENS_FORCE0      2'h3
`define SDOR_BOOT_DRV0        2'h0
`define SDOR_BOOT_DRV1        2'h1
`define SDOR_MUX_DRV0         2'h1
`define SDOR_PP_PRINTER       3'h4
`define SDOR_PP_SPP           3'h0
`define SDOR_PP_EPP19         3'h1
`define SDOR_PP_EPP17         3'h5
`define SDOR_PP_ECP           3'h2
`define SDOR_PP_ECP_EPP19     3'h3
`define SDOR_PP_ECP_EPP17     3'h7
`define SDOR_ECR_ECP          3'h3
`define SDOR_ECR_FIFO         3'h2
`define SDOR_ECR_TEST         3'h6

`endif

// ---- core/sdor_pkg.sv ----
/*
 * Types shared by the option register bank.
 * Assumes sdor_params.svh supplies the numbers.
 */
package sdor_pkg;

	// ==========================================================
	// parallel interrupt style
	typedef enum logic [1:0] {
		SDOR_IRQ_NACK,
		SDOR_IRQ_LEVEL,
		SDOR_IRQ_PULSE
	} sdor_irq_style_e;

	typedef logic [7:0] sdor_byte_t;

endpackage

// ---- core/sdor_irq_pulse.sv ----
/*
 * Parallel port interrupt shaper: level, nack-following or low pulse
 * then release.
 * Assumes all inputs are on clk; pulse width is a parameter.
 */
`timescale 1ns/100ps
`include "sdor_params.svh"

module sdor_irq_pulse #(
	parameter int PULSE_CYCLES = 4
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// control
	input  wire sdor_pkg::sdor_irq_style_e style,
	input  wire logic                     irq_req,
	input  wire logic                     nack_in,
	// pin
	output logic                          irq_out,
	output logic                          irq_oe
);

	typedef struct packed {
		logic       req_d;
		logic [7:0] cnt;
		logic       out;
		logic       oe;
	} sdor_irqp_s;

	sdor_irqp_s st_r;
	sdor_irqp_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.req_d = irq_req;
		case (style)
			sdor_pkg::SDOR_IRQ_PULSE: begin
				// low pulse on a rising request, then released
				if (irq_req && !st_r.req_d) begin
					st_nxt.cnt = 8'(PULSE_CYCLES);
				end else if (st_r.cnt != 8'h00) begin
					st_nxt.cnt = st_r.cnt - 8'h01;
				end
				st_nxt.out = 1'b0;
				st_nxt.oe  = (st_nxt.cnt != 8'h00);
			end
			sdor_pkg::SDOR_IRQ_NACK: begin
				st_nxt.cnt = 8'h00;
				st_nxt.out = irq_req & ~nack_in;
				st_nxt.oe  = 1'b1;
			end
			default: begin
				st_nxt.cnt = 8'h00;
				st_nxt.out = irq_req;
				st_nxt.oe  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign irq_out = st_r.out;
	assign irq_oe  = st_r.oe;

endmodule

// ---- core/sdor_option_regs.sv ----
/*
 * Vendor option registers of the floppy, parallel and first serial
 * logical devices, and the controls these settings drive.
 * Assumes a plain register port on clk, with the logical device number
 * selected outside; hard_rst is power-on or host reset, soft resets are
 * not connected here. Pin-level inputs arrive asynchronously.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`include "sdor_params.svh"

//Contract
//- Only hard reset restores defaults; soft reset leaves registers unchanged.
//- Floppy mode index F0 resets 0x0E; bit0 selects enhanced mode.
//- Floppy mode bit1: 0 burst DMA, 1 non-burst (default).
//- Floppy mode bits3:2 select interface style, 11 default AT.
//- Floppy mode bit4 swaps drive and motor selects of drives 0,1.
//- Floppy mode bit6: 0 open-drain outputs, 1 push-pull.
//- Floppy mode bit7 tristates floppy outputs; parallel-routed pins unaffected.
//- Floppy option F1 resets 0; bits3:2 control density output forcing.
//- Option bits7:6 select boot drive 0, 1, or none.
//- Drive types F2 resets 0xFF; A in 1:0, B in 3:2.
//- Floppy index F3 is read-only zero.
//- Drive 0 settings F4 reset 0; type, rate table, precomp disable.
//- Drive 1 settings F5 same layout and default as drive 0.
//- Parallel mode F0 resets 0x3C; bits2:0 select port mode.
//- Parallel mode bits6:3 hold ECP FIFO threshold, default 0111.
//- Parallel bit7 set gives low pulse interrupt, not in printer/SPP.
//- Parallel bit7 clear: interrupt follows nACK in EPP, else level; code follows nACK outside printer/SPP unless ECR is ECP, FIFO or test.
//- Parallel second mode F1 resets 0; code 01 puts drive 0 on port.
//- Serial one mode F0 resets 0; bit0 MIDI, bit1 high speed.
//- Serial bit7 makes both UARTs share one interrupt line.
//- Share set with two lines assigned: both lines assert on either.
module sdor_option_regs #(
	parameter int PULSE_CYCLES = 4
) (
	// clock and hard reset
	input  wire logic       clk,
	input  wire logic       hard_rst,
	// register port
	input  wire logic [7:0] ldn,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// floppy core controls
	output logic            fdc_enhanced,
	output logic            fdc_burst,
	output logic      [1:0] fdc_if_style,
	output logic      [1:0] fdc_drive_a_type,
	output logic      [1:0] fdc_drive_b_type,
	output logic      [1:0] drive_type_sel0,
	output logic      [1:0] rate_table_sel0,
	output logic            precomp_disable0,
	output logic      [1:0] drive_type_sel1,
	output logic      [1:0] rate_table_sel1,
	output logic            precomp_disable1,
	output logic            boot_valid,
	output logic            boot_drive,
	// floppy pins
	input  wire logic [1:0] core_drive_sel_n,
	input  wire logic [1:0] core_motor_n,
	input  wire logic       core_density,
	output logic      [1:0] drive_sel_n_out,
	output logic      [1:0] drive_sel_n_oe,
	output logic      [1:0] motor_n_out,
	output logic      [1:0] motor_n_oe,
	output logic            density_out,
	output logic            density_oe,
	// floppy on parallel pins
	output logic            drive0_on_parallel,
	output logic            pp_drive_sel_n,
	output logic            pp_motor_n,
	// parallel port controls
	output logic      [2:0] pp_mode,
	output logic      [3:0] pp_fifo_threshold,
	input  wire logic [2:0] ecr_mode,
	input  wire logic       pp_irq_req,
	input  wire logic       nack_pin,
	output logic            pp_irq_out,
	output logic            pp_irq_oe,
	// serial controls
	output logic            midi_enable,
	output logic            high_speed,
	input  wire logic       uart1_irq,
	input  wire logic       uart2_irq,
	input  wire logic       uart1_irq_assigned,
	input  wire logic       uart2_irq_assigned,
	output logic            uart1_irq_line,
	output logic            uart2_irq_line
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] fmode;
		logic [7:0] fopt;
		logic [7:0] ftypes;
		logic [7:0] drv0;
		logic [7:0] drv1;
		logic [7:0] pmode;
		logic [7:0] pmode2;
		logic [7:0] smode;
		logic [7:0] rdata;
		logic [1:0] nack_sync;
	} sdor_regs_s;

	sdor_regs_s st_r;
	sdor_regs_s st_nxt;

	function automatic logic [7:0] merge(input logic [7:0] mask, input logic [7:0] d);
		merge = d & mask;
	endfunction

	function automatic logic hit(input logic [7:0] dev, input logic [7:0] idx);
		hit = (ldn == dev) && (addr == idx);
	endfunction

	// ==========================================================
	// register file
	always_comb begin
		st_nxt = st_r;
		st_nxt.nack_sync = {st_r.nack_sync[0], nack_pin};
		st_nxt.rdata = 8'h00;
		if (wr) begin
			if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_MODE)) begin
				st_nxt.fmode = merge(`SDOR_MASK_FMODE, wdata);
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_OPTION)) begin
				st_nxt.fopt = merge(`SDOR_MASK_FOPT, wdata);
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_TYPES)) begin
				st_nxt.ftypes = merge(`SDOR_MASK_FTYPES, wdata);
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_DRV0)) begin
				st_nxt.drv0 = merge(`SDOR_MASK_DRV, wdata);
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_DRV1)) begin
				st_nxt.drv1 = merge(`SDOR_MASK_DRV, wdata);
			end else if (hit(`SDOR_LDN_PARALLEL, `SDOR_IDX_MODE)) begin
				st_nxt.pmode = merge(`SDOR_MASK_PMODE, wdata);
			end else if (hit(`SDOR_LDN_PARALLEL, `SDOR_IDX_OPTION)) begin
				st_nxt.pmode2 = merge(`SDOR_MASK_PMODE2, wdata);
			end else if (hit(`SDOR_LDN_SERIAL1, `SDOR_IDX_MODE)) begin
				st_nxt.smode = merge(`SDOR_MASK_SMODE, wdata);
			end
		end
		if (rd) begin
			// unmapped indices, and the fixed zero index, read as zero
			if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_MODE)) begin
				st_nxt.rdata = st_r.fmode;
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_OPTION)) begin
				st_nxt.rdata = st_r.fopt;
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_TYPES)) begin
				st_nxt.rdata = st_r.ftypes;
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_ZERO)) begin
				st_nxt.rdata = 8'h00;
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_DRV0)) begin
				st_nxt.rdata = st_r.drv0;
			end else if (hit(`SDOR_LDN_FLOPPY, `SDOR_IDX_DRV1)) begin
				st_nxt.rdata = st_r.drv1;
			end else if (hit(`SDOR_LDN_PARALLEL, `SDOR_IDX_MODE)) begin
				st_nxt.rdata = st_r.pmode;
			end else if (hit(`SDOR_LDN_PARALLEL, `SDOR_IDX_OPTION)) begin
				st_nxt.rdata = st_r.pmode2;
			end else if (hit(`SDOR_LDN_SERIAL1, `SDOR_IDX_MODE)) begin
				st_nxt.rdata = st_r.smode;
			end
		end
	end

	// hard reset only; soft resets never reach this block
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			st_r.fmode     <= `SDOR_RST_FMODE;
			st_r.fopt      <= `SDOR_RST_FOPT;
			st_r.ftypes    <= `SDOR_RST_FTYPES;
			st_r.drv0      <= `SDOR_RST_DRV;
			st_r.drv1      <= `SDOR_RST_DRV;
			st_r.pmode     <= `SDOR_RST_PMODE;
			st_r.pmode2    <= `SDOR_RST_PMODE2;
			st_r.smode     <= `SDOR_RST_SMODE;
			st_r.rdata     <= 8'h00;
			st_r.nack_sync <= 2'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;

	// ==========================================================
	// floppy controls
	logic swap;
	logic [1:0] dens_code;
	logic [1:0] boot_code;

	assign fdc_enhanced     = st_r.fmode[`SDOR_FM_ENH];
	assign fdc_burst        = ~st_r.fmode[`SDOR_FM_NOBURST];
	assign fdc_if_style     = st_r.fmode[`SDOR_FM_IF_HI:`SDOR_FM_IF_LO];
	assign fdc_drive_a_type = st_r.ftypes[`SDOR_FT_A_HI:`SDOR_FT_A_LO];
	assign fdc_drive_b_type = st_r.ftypes[`SDOR_FT_B_HI:`SDOR_FT_B_LO];
	assign drive_type_sel0  = st_r.drv0[`SDOR_DR_TYPE_HI:`SDOR_DR_TYPE_LO];
	assign rate_table_sel0  = st_r.drv0[`SDOR_DR_RATE_HI:`SDOR_DR_RATE_LO];
	assign precomp_disable0 = st_r.drv0[`SDOR_DR_PRECOMP];
	assign drive_type_sel1  = st_r.drv1[`SDOR_DR_TYPE_HI:`SDOR_DR_TYPE_LO];
	assign rate_table_sel1  = st_r.drv1[`SDOR_DR_RATE_HI:`SDOR_DR_RATE_LO];
	assign precomp_disable1 = st_r.drv1[`SDOR_DR_PRECOMP];

	assign boot_code  = st_r.fopt[`SDOR_FO_BOOT_HI:`SDOR_FO_BOOT_LO];
	assign boot_valid = (boot_code == `SDOR_BOOT_DRV0) || (boot_code == `SDOR_BOOT_DRV1);
	assign boot_drive = (boot_code == `SDOR_BOOT_DRV1);

	assign swap         = st_r.fmode[`SDOR_FM_SWAP];
	assign dens_code    = st_r.fopt[`SDOR_FO_DENS_HI:`SDOR_FO_DENS_LO];

	// open-drain drives only low; push-pull drives both levels
	// mode is an argument; st_r.fmode is passed, so the enables follow the registered mode
	function automatic logic pin_oe(input logic [7:0] mode, input logic level);
		pin_oe = ~mode[`SDOR_FM_TRISTATE] & (mode[`SDOR_FM_PUSHPULL] | ~level);
	endfunction

	logic [1:0] sel_mapped;
	logic [1:0] mot_mapped;
	logic       dens_val;

	assign sel_mapped = swap ? {core_drive_sel_n[0], core_drive_sel_n[1]}
	                         : core_drive_sel_n;
	assign mot_mapped = swap ? {core_motor_n[0], core_motor_n[1]} : core_motor_n;

	always_comb begin
		if (dens_code == `SDOR_DENS_FORCE1) begin
			dens_val = 1'b1;
		end else if (dens_code == `SDOR_DENS_FORCE0) begin
			dens_val = 1'b0;
		end else begin
			dens_val = core_density;
		end
	end

	assign drive_sel_n_out = sel_mapped;
	assign motor_n_out     = mot_mapped;
	assign density_out     = dens_val;
	assign drive_sel_n_oe  = {pin_oe(st_r.fmode, sel_mapped[1]), pin_oe(st_r.fmode, sel_mapped[0])};
	assign motor_n_oe      = {pin_oe(st_r.fmode, mot_mapped[1]), pin_oe(st_r.fmode, mot_mapped[0])};
	assign density_oe      = pin_oe(st_r.fmode, dens_val);

	// parallel-routed floppy signals ignore output type and tristate bits
	assign drive0_on_parallel = (st_r.pmode2[`SDOR_PM2_MUX_HI:`SDOR_PM2_MUX_LO]
	                             == `SDOR_MUX_DRV0);
	assign pp_drive_sel_n = drive0_on_parallel ? sel_mapped[0] : 1'b1;
	assign pp_motor_n     = drive0_on_parallel ? mot_mapped[0] : 1'b1;

	// ==========================================================
	// parallel port controls
	sdor_pkg::sdor_irq_style_e irq_style;

	assign pp_mode           = st_r.pmode[`SDOR_PM_MODE_HI:`SDOR_PM_MODE_LO];
	assign pp_fifo_threshold = st_r.pmode[`SDOR_PM_THR_HI:`SDOR_PM_THR_LO];

	always_comb begin
		if (st_r.pmode[`SDOR_PM_PULSE] && (pp_mode != `SDOR_PP_PRINTER)
		    && (pp_mode != `SDOR_PP_SPP)) begin
			irq_style = sdor_pkg::SDOR_IRQ_PULSE;
		end else if ((ecr_mode == `SDOR_ECR_ECP) || (ecr_mode == `SDOR_ECR_FIFO)
		             || (ecr_mode == `SDOR_ECR_TEST)) begin
			irq_style = sdor_pkg::SDOR_IRQ_LEVEL;
		end else if ((pp_mode == `SDOR_PP_PRINTER) || (pp_mode == `SDOR_PP_SPP)) begin
			irq_style = sdor_pkg::SDOR_IRQ_LEVEL;
		end else begin
			irq_style = sdor_pkg::SDOR_IRQ_NACK;
		end
	end

	sdor_irq_pulse #(
		.PULSE_CYCLES (PULSE_CYCLES)
	) u_irq (
		.clk     (clk),
		.rst     (hard_rst),
		.style   (irq_style),
		.irq_req (pp_irq_req),
		.nack_in (st_r.nack_sync[1]),
		.irq_out (pp_irq_out),
		.irq_oe  (pp_irq_oe)
	);

	// ==========================================================
	// serial controls
	logic share;

	assign midi_enable = st_r.smode[`SDOR_SM_MIDI];
	assign high_speed  = st_r.smode[`SDOR_SM_HISPEED];
	assign share       = st_r.smode[`SDOR_SM_SHARE];

	// with one line unassigned (as software is expected to set up) the
	// unassigned output goes nowhere; with two assigned both fire
	assign uart1_irq_line = share ? (uart1_irq | uart2_irq) : uart1_irq;
	assign uart2_irq_line = share ? (uart1_irq | uart2_irq) : uart2_irq;

endmodule

// ---- tb/sdor_option_regs_properties.sv ----
/*
 * Concurrent checks on the ports of the option register bank.
 * Assumes one clock, sync active-high hard reset, and is bound below.
 */
`timescale 1ns/100ps
`include "sdor_params.svh"

module sdor_option_props #(
	parameter int PULSE_CYCLES = 4
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       hard_rst,
	// register port
	input wire logic [7:0] ldn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// decoded controls
	input wire logic       fdc_enhanced,
	input wire logic       fdc_burst,
	input wire logic [1:0] fdc_if_style,
	input wire logic [1:0] fdc_drive_a_type,
	input wire logic [1:0] fdc_drive_b_type,
	input wire logic [1:0] drive_type_sel0,
	input wire logic [1:0] rate_table_sel0,
	input wire logic       precomp_disable0,
	input wire logic [1:0] drive_type_sel1,
	input wire logic [1:0] rate_table_sel1,
	input wire logic       precomp_disable1,
	input wire logic       boot_valid,
	input wire logic       boot_drive,
	// pins, then parallel and serial controls
	input wire logic [1:0] drive_sel_n_oe,
	input wire logic [1:0] motor_n_oe,
	input wire logic       density_oe,
	input wire logic       drive0_on_parallel,
	input wire logic       pp_drive_sel_n,
	input wire logic       pp_motor_n,
	input wire logic [2:0] pp_mode,
	input wire logic [3:0] pp_fifo_threshold,
	input wire logic       midi_enable,
	input wire logic       high_speed
);
	wire fw = wr && ldn == `SDOR_LDN_FLOPPY;
	wire pw = wr && ldn == `SDOR_LDN_PARALLEL;
	wire sw = wr && ldn == `SDOR_LDN_SERIAL1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (hard_rst);

	// ==========================================================
	// properties
	a_hard_defaults: assert property (disable iff (1'b0) hard_rst |=>
		pp_mode == 3'h4 && pp_fifo_threshold == 4'h7 && !fdc_burst && fdc_if_style == 2'h3
		&& fdc_drive_a_type == 2'h3 && boot_valid && !boot_drive && !midi_enable)
		else $error("defaults missing after hard reset");
	a_idle_zero: assert property (!rd |=> rdata == 8'h00)
		else $error("read data outside read slot");
	a_zero_index: assert property (rd && ldn == 8'h00 && addr == 8'hF3 |=>
		rdata == 8'h00)
		else $error("read-only index not zero");
	a_fmode_decode: assert property (fw && addr == 8'hF0 |=>
		fdc_enhanced == $past(wdata[0]) && fdc_burst == !$past(wdata[1])
		&& fdc_if_style == $past(wdata[3:2]))
		else $error("floppy mode fields wrong");
	a_tristate_all: assert property (fw && addr == 8'hF0 && wdata[7] |=>
		drive_sel_n_oe == 2'b00 && motor_n_oe == 2'b00 && !density_oe)
		else $error("floppy pins driven while tristated");
	a_boot_code: assert property (fw && addr == 8'hF1 |=>
		boot_valid == !$past(wdata[7]) && (!boot_valid || boot_drive == $past(wdata[6])))
		else $error("boot drive wrong");
	a_types_decode: assert property (fw && addr == 8'hF2 |=>
		fdc_drive_a_type == $past(wdata[1:0]) && fdc_drive_b_type == $past(wdata[3:2]))
		else $error("drive types wrong");
	a_drive0_fields: assert property (fw && addr == 8'hF4 |=>
		drive_type_sel0 == $past(wdata[1:0]) && rate_table_sel0 == $past(wdata[4:3])
		&& precomp_disable0 == $past(wdata[6]))
		else $error("drive 0 fields wrong");
	a_drive1_fields: assert property (fw && addr == 8'hF5 |=>
		drive_type_sel1 == $past(wdata[1:0]) && rate_table_sel1 == $past(wdata[4:3])
		&& precomp_disable1 == $past(wdata[6]))
		else $error("drive 1 fields wrong");
	a_pmode_fields: assert property (pw && addr == 8'hF0 |=>
		pp_mode == $past(wdata[2:0]) && pp_fifo_threshold == $past(wdata[6:3]))
		else $error("parallel mode fields wrong");
	a_mux_idle: assert property (!drive0_on_parallel |-> pp_drive_sel_n && pp_motor_n)
		else $error("parallel pins carry floppy signals");
	a_serial_bits: assert property (sw && addr == 8'hF0 |=>
		midi_enable == $past(wdata[0]) && high_speed == $past(wdata[1]))
		else $error("serial mode fields wrong");
endmodule

bind sdor_option_regs sdor_option_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
	.clk, .hard_rst, .ldn, .addr, .wdata, .wr, .rd, .rdata, .fdc_enhanced, .fdc_burst,
	.fdc_if_style, .fdc_drive_a_type, .fdc_drive_b_type, .drive_type_sel0, .rate_table_sel0,
	.precomp_disable0, .drive_type_sel1, .rate_table_sel1, .precomp_disable1, .boot_valid,
	.boot_drive, .drive_sel_n_oe, .motor_n_oe, .density_oe, .drive0_on_parallel,
	.pp_drive_sel_n, .pp_motor_n, .pp_mode, .pp_fifo_threshold, .midi_enable, .high_speed
);

// ---- tb/superio_device_option_regs_tb_top.sv ----
/*
 * Bench for the option register bank: defaults, read back, pins,
 * interrupt styles and shared serial lines.
 * Assumes the checker file is compiled with it.
 */
`timescale 1ns/100ps

module superio_device_option_regs_tb_top;
	logic        clk, hard_rst, wr, rd, core_density, pp_irq_req, nack_pin, rd_d;
	logic        uart1_irq, uart2_irq, uart1_irq_assigned, uart2_irq_assigned;
	logic [7:0]  ldn, addr, wdata, rdata, e;
	logic [2:0]  ecr_mode, pp_mode;
	logic [1:0]  core_drive_sel_n, core_motor_n, fdc_if_style, fdc_drive_a_type;
	logic [1:0]  fdc_drive_b_type, drive_type_sel0, rate_table_sel0, drive_type_sel1;
	logic [1:0]  rate_table_sel1, drive_sel_n_out, drive_sel_n_oe, motor_n_out, motor_n_oe;
	logic [3:0]  pp_fifo_threshold;
	logic        fdc_enhanced, fdc_burst, precomp_disable0, precomp_disable1, boot_valid;
	logic        boot_drive, density_out, density_oe, drive0_on_parallel, pp_drive_sel_n;
	logic        pp_motor_n, pp_irq_out, pp_irq_oe, midi_enable, high_speed;
	logic        uart1_irq_line, uart2_irq_line;
	int          err_count, checked, cyc;
	logic [31:0] seed;
	sdor_pkg::sdor_byte_t exp_q[$];
	// ldn, index, default, writable mask; last two are unmapped
	logic [31:0] tab [11] = '{32'h00F00EDF, 32'h00F100CC, 32'h00F2FFFF, 32'h00F30000,
		32'h00F4005B, 32'h00F5005B, 32'h03F03CFF, 32'h03F10003, 32'h04F00083,
		32'h00F60000, 32'h05F00000};
	// floppy mode, then masked sel out, sel oe, motor out, motor oe
	logic [15:0] pins [4] = '{16'h4EB7, 16'h5E7B, 16'h0E12, 16'hCE00};
	// parallel mode, ecr mode, nack level, then out, oe and pulse length
	logic [31:0] irqs [8] = '{32'hBC0001C0, 32'hB80001C0, 32'h39000149, 32'h390000C0,
		32'h3A0301C0, 32'hBA000004, 32'h3A0201C0, 32'h3A0601C0};
	// serial mode, both irqs, both expected lines
	logic [15:0] ser [4] = '{16'h8023, 16'h8013, 16'h0011, 16'h0022};

	sdor_option_regs #(.PULSE_CYCLES(4)) dut (
		.clk, .hard_rst, .ldn, .addr, .wdata, .wr, .rd, .rdata, .fdc_enhanced, .fdc_burst,
		.fdc_if_style, .fdc_drive_a_type, .fdc_drive_b_type, .drive_type_sel0,
		.rate_table_sel0, .precomp_disable0, .drive_type_sel1, .rate_table_sel1,
		.precomp_disable1, .boot_valid, .boot_drive, .core_drive_sel_n, .core_motor_n,
		.core_density, .drive_sel_n_out, .drive_sel_n_oe, .motor_n_out, .motor_n_oe,
		.density_out, .density_oe, .drive0_on_parallel, .pp_drive_sel_n, .pp_motor_n,
		.pp_mode, .pp_fifo_threshold, .ecr_mode, .pp_irq_req, .nack_pin, .pp_irq_out,
		.pp_irq_oe, .midi_enable, .high_speed, .uart1_irq, .uart2_irq, .uart1_irq_assigned,
		.uart2_irq_assigned, .uart1_irq_line, .uart2_irq_line
	);

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmp(input logic [7:0] g, input logic [7:0] x);
		checked++;
		if (g !== x) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, x);
		end
	endtask

	// strobes stay up between back-to-back calls; idle drops them
	task automatic bus(input logic w, input logic [7:0] l, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		ldn <= l;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
	endtask

	task automatic rreg(input logic [7:0] l, input logic [7:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		bus(1'b0, l, a, 8'h00);
	endtask

	task automatic idle();
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
	endtask

	task automatic sweep();
		for (int i = 0; i < 11; i++) begin
			rreg(tab[i][31:24], tab[i][23:16], tab[i][15:8]);
		end
		idle();
	endtask

	task automatic irq_try(input logic [31:0] t);
		logic [5:0] n;
		bus(1'b1, 8'h03, 8'hF0, t[31:24]);
		ecr_mode <= t[18:16];
		nack_pin <= t[8];
		idle();
		repeat (4) @(posedge clk);
		pp_irq_req <= 1'b1;
		n = 6'h00;
		@(negedge clk);
		repeat (9) begin
			@(negedge clk);
			n = n + 6'(pp_irq_oe === 1'b1 && pp_irq_out === 1'b0);
		end
		cmp({pp_irq_out & pp_irq_oe, pp_irq_oe, n}, t[7:0]);
		@(posedge clk);
		pp_irq_req <= 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// clock, read watcher, timeout
	initial begin
		clk = 1'b0;
		forever begin
			#4 clk = ~clk;
		end
	end

	always @(posedge clk) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			$display("BAD %0t run too long", $time);
			conclude();
		end
	end

	always @(negedge clk) begin
		if (rd_d === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("BAD %0t read without note", $time);
			end else begin
				cmp(rdata, exp_q.pop_front());
			end
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		{hard_rst, wr, rd, core_density, pp_irq_req, nack_pin} = 6'h20;
		{uart1_irq, uart2_irq, uart1_irq_assigned, uart2_irq_assigned} = 4'h0;
		{ldn, addr, wdata, ecr_mode} = 27'h0;
		core_drive_sel_n = 2'b10;
		core_motor_n = 2'b01;
		seed = 32'h036D;
		repeat (16) @(posedge clk);
		hard_rst <= 1'b0;
		sweep();
		for (int i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			bus(1'b1, tab[i][31:24], tab[i][23:16], seed[7:0]);
			rreg(tab[i][31:24], tab[i][23:16], seed[7:0] & tab[i][7:0]);
		end
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, 8'h03, 8'hF0, 8'h38 | 8'(m));
			rreg(8'h03, 8'hF0, 8'h38 | 8'(m));
		end
		idle();
		@(posedge clk);
		hard_rst <= 1'b1;
		@(posedge clk);
		hard_rst <= 1'b0;
		sweep();
		bus(1'b1, 8'h03, 8'hF1, 8'h01);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h00, 8'hF0, pins[i][15:8]);
			idle();
			e = {drive_sel_n_out & drive_sel_n_oe, drive_sel_n_oe, motor_n_out & motor_n_oe,
				motor_n_oe};
			cmp(e, pins[i][7:0]);
		end
		cmp({5'h00, drive0_on_parallel, pp_drive_sel_n, pp_motor_n}, 8'h05);
		bus(1'b1, 8'h00, 8'hF0, 8'h4E);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, 8'h00, 8'hF1, {c[1:0], 2'b00, c[1:0], 2'b00});
			core_density <= c[0];
			idle();
			e = {4'h0, !c[1], !c[1] & c[0], c[1] ^ c[0], 1'b1};
			cmp({4'h0, boot_valid, boot_valid & boot_drive, density_out, density_oe}, e);
		end
		for (int i = 0; i < 8; i++) begin
			irq_try(irqs[i]);
		end
		uart1_irq_assigned <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h04, 8'hF0, ser[i][15:8]);
			uart1_irq <= ser[i][5];
			uart2_irq <= ser[i][4];
			uart2_irq_assigned <= (i != 0);
			idle();
			cmp({6'h00, uart1_irq_line, uart2_irq_line}, {6'h00, ser[i][1:0]});
		end
		repeat (3) @(posedge clk);
		cmp(8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule
